//--- rtl/sfd_pkg.sv
package sfd_pkg;

   // Register word offsets on the bus.
   localparam logic [7:0] ADDR_FEATURE  = 8'h00;
   localparam logic [7:0] ADDR_COUNT    = 8'h04;
   localparam logic [7:0] ADDR_SECNUM   = 8'h08;
   localparam logic [7:0] ADDR_MID      = 8'h0c;
   localparam logic [7:0] ADDR_HIGH     = 8'h10;
   localparam logic [7:0] ADDR_DEVSEL   = 8'h14;
   localparam logic [7:0] ADDR_COMMAND  = 8'h18;
   localparam logic [7:0] ADDR_ERROR    = 8'h1c;
   localparam logic [7:0] ADDR_STATE    = 8'h20;
   localparam logic [7:0] ADDR_LINKFEAT = 8'h24;
   localparam logic [7:0] ADDR_POWER    = 8'h28;
   localparam logic [7:0] ADDR_LOWTMO   = 8'h2c;
   localparam logic [7:0] ADDR_STBTMO   = 8'h30;
   localparam logic [7:0] ADDR_SECTIME  = 8'h34;
   localparam logic [7:0] ADDR_CONTROL  = 8'h38;
   localparam logic [7:0] ADDR_CONDCAP  = 8'h3c;

   // Command and selector codes.
   localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
   localparam logic [7:0] SEL_LINK_ENABLE  = 8'h10;
   localparam logic [7:0] SEL_LINK_DISABLE = 8'h90;
   localparam logic [7:0] SEL_PWR_ENABLE   = 8'h05;
   localparam logic [7:0] SEL_PWR_DISABLE  = 8'h85;
   localparam logic [7:0] SEL_SECTOR_TIME  = 8'h43;
   localparam logic [7:0] SEL_EXT_POWER    = 8'h4a;
   localparam logic [7:0] SEL_WCACHE_ON    = 8'h02;
   localparam logic [7:0] SEL_XFER_MODE    = 8'h03;
   localparam logic [7:0] SEL_PUIS_ON      = 8'h06;
   localparam logic [7:0] SEL_PUIS_SPINUP  = 8'h07;
   localparam logic [7:0] SEL_RLA_OFF      = 8'h55;
   localparam logic [7:0] SEL_REVERT_OFF   = 8'h66;
   localparam logic [7:0] SEL_WCACHE_OFF   = 8'h82;
   localparam logic [7:0] SEL_PUIS_OFF     = 8'h86;
   localparam logic [7:0] SEL_RLA_ON       = 8'haa;
   localparam logic [7:0] SEL_REVERT_ON    = 8'hcc;

   // Link feature codes.
   localparam logic [7:0] LF_BUF_OFFSET   = 8'h01;
   localparam logic [7:0] LF_AUTO_ACT     = 8'h02;
   localparam logic [7:0] LF_DEV_PWR      = 8'h03;
   localparam logic [7:0] LF_IN_ORDER     = 8'h04;
   localparam logic [7:0] LF_PRESERVE     = 8'h06;
   localparam logic [4:0] LINK_FEAT_RESET = 5'h00;

   // Level boundaries.
   localparam logic [7:0] LVL_ABORT_LO  = 8'h00;
   localparam logic [7:0] LVL_ABORT_HI  = 8'hff;
   localparam logic [7:0] LVL_NORMAL_LO = 8'hc0;
   localparam logic [7:0] LVL_LOWIDL_LO = 8'h80;
   localparam logic [7:0] LVL_STBY_SCAL = 8'h40;

   // Timeouts in seconds.
   localparam logic [12:0] LOWIDL_BASE_S = 13'd120;
   localparam logic [12:0] LOWIDL_STEP_S = 13'd5;
   localparam logic [12:0] STBY_BASE_S   = 13'd600;
   localparam logic [12:0] STBY_STEP_S   = 13'd60;

   // Restore subcommand parameter layout, error abort bit and status bit positions.
   localparam logic [3:0] EPC_RESTORE    = 4'h0;
   localparam int         EPC_DEFAULT_B  = 6;
   localparam int         EPC_SAVE_B     = 4;
   localparam int         ERR_ABORT_B    = 2;
   localparam int         ST_READY_B     = 6;
   localparam int         ST_ERROR_B     = 0;

   // Seconds to clock cycles at 250 MHz.
   localparam int unsigned CLK_HZ     = 250_000_000;
   localparam int unsigned ONE_S_NS   = 1_000_000_000;
   localparam int unsigned CLK_NS     = ONE_S_NS / CLK_HZ;
   localparam int unsigned SEC_CYCLES = ONE_S_NS / CLK_NS;

   typedef enum logic [1:0] {
      SFD_NORMAL = 2'b00,
      SFD_LOWIDL = 2'b01,
      SFD_STBY   = 2'b10
   } sfd_deep_t;

   typedef enum logic [1:0] {
      SFD_ACT  = 2'b00,
      SFD_LIDL = 2'b01,
      SFD_RSB  = 2'b10
   } sfd_pstate_t;

endpackage

//--- rtl/sfd_level_decode.sv
`timescale 1ns/1ps
module sfd_level_decode
(
   // Level in.
   input  wire logic [7:0]        level,
   // Decoded result.
   output sfd_pkg::sfd_deep_t     deepest,
   output logic                   level_abort,
   output logic [12:0]            low_idle_s,
   output logic [12:0]            stby_s
);

   logic [12:0] lv;
   assign lv = {5'h00, level};

   always_comb
   begin
      level_abort = 1'b0;
      deepest     = sfd_pkg::SFD_NORMAL;
      low_idle_s  = sfd_pkg::LOWIDL_BASE_S;
      stby_s      = sfd_pkg::STBY_BASE_S;
      if (level == sfd_pkg::LVL_ABORT_LO || level == sfd_pkg::LVL_ABORT_HI)
      begin
         level_abort = 1'b1;
      end
      else if (level >= sfd_pkg::LVL_NORMAL_LO)
      begin
         deepest = sfd_pkg::SFD_NORMAL;
      end
      else if (level >= sfd_pkg::LVL_LOWIDL_LO)
      begin
         deepest    = sfd_pkg::SFD_LOWIDL;
         low_idle_s = 13'((lv - 13'h080) * sfd_pkg::LOWIDL_STEP_S
                      + sfd_pkg::LOWIDL_BASE_S);
      end
      else
      begin
         deepest = sfd_pkg::SFD_STBY;
         if (level >= sfd_pkg::LVL_STBY_SCAL)
         begin
            stby_s = 13'((lv - 13'h040) * sfd_pkg::STBY_STEP_S
                     + sfd_pkg::STBY_BASE_S);
         end
         else
         begin
            stby_s = sfd_pkg::STBY_BASE_S;
         end
      end
   end

endmodule

//--- rtl/sfd_idle_timer.sv
`timescale 1ns/1ps
module sfd_idle_timer
#(
   parameter int unsigned SEC_CYCLES = sfd_pkg::SEC_CYCLES
)
(
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Control.
   input  wire logic              restart,
   // Elapsed idle seconds.
   output logic [12:0]            idle_s
);

   logic [31:0] tick;

   // The seconds count saturates so a long idle never wraps back to zero.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tick   <= 32'h0;
         idle_s <= 13'h0;
      end
      else if (restart)
      begin
         tick   <= 32'h0;
         idle_s <= 13'h0;
      end
      else if (tick >= 32'(SEC_CYCLES - 1))
      begin
         tick <= 32'h0;
         if (idle_s != 13'h1fff)
         begin
            idle_s <= idle_s + 13'h1;
         end
      end
      else
      begin
         tick <= tick + 32'h1;
      end
   end

endmodule

//--- rtl/sfd_top.sv
`timescale 1ns/1ps
module sfd_top
#(
   parameter int unsigned SEC_CYCLES = sfd_pkg::SEC_CYCLES
)
(
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              reset_n,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Device resets and activity.
   input  wire logic              hard_reset,
   input  wire logic              soft_reset,
   input  wire logic              host_activity,
   // Power drive outputs.
   output logic                   electronics_off,
   output logic                   heads_parked,
   output logic                   spindle_reduced,
   // Pacing limits, zero meaning none.
   output logic [15:0]            pio_sector_limit,
   output logic [15:0]            dma_sector_limit,
   output logic                   pio_pacing_on,
   output logic                   dma_pacing_on
);

   logic [7:0]  feature_selector;
   logic [7:0]  sector_count_param;
   logic [7:0]  sector_number_param;
   logic [7:0]  address_mid_byte;
   logic [7:0]  address_high_byte;
   logic [7:0]  device_select;
   logic [7:0]  error_flags;
   logic [7:0]  device_state;
   logic [4:0]  link_feat;
   logic        power_level_management;
   logic [7:0]  power_level;
   sfd_pkg::sfd_deep_t  deepest;
   sfd_pkg::sfd_pstate_t pstate;
   logic [12:0] low_idle_timeout;
   logic [12:0] reduced_speed_standby_timeout;
   logic        low_idle_set;
   logic        revert_enable;
   logic [15:0] pio_time;
   logic [15:0] dma_time;
   logic [3:0]  cond_supported;
   logic [3:0]  cond_changeable;
   logic [3:0]  cond_saveable;
   logic [3:0]  cond_saved;
   logic [3:0]  cond_enabled;

   logic        wr;
   logic        cmd_go;
   logic        dec_abort;
   sfd_pkg::sfd_deep_t dec_deep;
   logic [12:0] dec_low_s;
   logic [12:0] dec_stby_s;
   logic [12:0] idle_s;
   logic        reinit;
   logic        abort_flag;
   logic        link_ok;
   logic [4:0]  link_mask;
   logic        epc_abort;
   logic        restore_cmd;

   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite;
   assign cmd_go  = wr && paddr == sfd_pkg::ADDR_COMMAND
                    && pwdata[7:0] == sfd_pkg::CMD_SET_FEATURES;
   // A soft reset keeps power settings while reverting is disabled.
   assign reinit  = hard_reset || (soft_reset && revert_enable);

   sfd_level_decode u_dec
   (
      .level       (sector_count_param),
      .deepest     (dec_deep),
      .level_abort (dec_abort),
      .low_idle_s  (dec_low_s),
      .stby_s      (dec_stby_s)
   );

   sfd_idle_timer #(.SEC_CYCLES(SEC_CYCLES)) u_tmr
   (
      .clk     (clk),
      .reset_n (reset_n),
      .restart (host_activity || cmd_go || reinit),
      .idle_s  (idle_s)
   );

   always_comb
   begin
      link_ok   = 1'b1;
      link_mask = 5'h00;
      unique case (sector_count_param)
         sfd_pkg::LF_BUF_OFFSET: link_mask = 5'h01;
         sfd_pkg::LF_AUTO_ACT:   link_mask = 5'h02;
         sfd_pkg::LF_DEV_PWR:    link_mask = 5'h04;
         sfd_pkg::LF_IN_ORDER:   link_mask = 5'h08;
         sfd_pkg::LF_PRESERVE:   link_mask = 5'h10;
         default:                link_ok   = 1'b0;
      endcase
   end

   // Restore addresses every condition; all must be supported and changeable, and saveable too when the save bit is set.
   assign restore_cmd = sector_number_param[3:0] == sfd_pkg::EPC_RESTORE;
   assign epc_abort   = !restore_cmd
                        || cond_supported != 4'hf
                        || cond_changeable != 4'hf
                        || (sector_number_param[sfd_pkg::EPC_SAVE_B]
                            && cond_saveable != 4'hf);

   always_comb
   begin
      unique case (feature_selector)
         sfd_pkg::SEL_LINK_ENABLE,
         sfd_pkg::SEL_LINK_DISABLE: abort_flag = !link_ok;
         sfd_pkg::SEL_PWR_ENABLE:   abort_flag = dec_abort;
         sfd_pkg::SEL_EXT_POWER:    abort_flag = epc_abort;
         sfd_pkg::SEL_PWR_DISABLE,
         sfd_pkg::SEL_SECTOR_TIME,
         sfd_pkg::SEL_WCACHE_ON,
         sfd_pkg::SEL_XFER_MODE,
         sfd_pkg::SEL_PUIS_ON,
         sfd_pkg::SEL_PUIS_SPINUP,
         sfd_pkg::SEL_RLA_OFF,
         sfd_pkg::SEL_REVERT_OFF,
         sfd_pkg::SEL_WCACHE_OFF,
         sfd_pkg::SEL_PUIS_OFF,
         sfd_pkg::SEL_RLA_ON,
         sfd_pkg::SEL_REVERT_ON:    abort_flag = 1'b0;
         default:                   abort_flag = 1'b1;
      endcase
   end

   // Taskfile parameter registers.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         feature_selector    <= 8'h00;
         sector_count_param  <= 8'h00;
         sector_number_param <= 8'h00;
         address_mid_byte    <= 8'h00;
         address_high_byte   <= 8'h00;
         device_select       <= 8'h00;
         cond_supported      <= 4'hf;
         cond_changeable     <= 4'hf;
         cond_saveable       <= 4'hf;
      end
      else if (wr)
      begin
         unique case (paddr)
            sfd_pkg::ADDR_FEATURE: feature_selector    <= pwdata[7:0];
            sfd_pkg::ADDR_COUNT:   sector_count_param  <= pwdata[7:0];
            sfd_pkg::ADDR_SECNUM:  sector_number_param <= pwdata[7:0];
            sfd_pkg::ADDR_MID:     address_mid_byte    <= pwdata[7:0];
            sfd_pkg::ADDR_HIGH:    address_high_byte   <= pwdata[7:0];
            sfd_pkg::ADDR_DEVSEL:  device_select       <= pwdata[7:0];
            sfd_pkg::ADDR_CONDCAP:
            begin
               cond_supported  <= pwdata[3:0];
               cond_changeable <= pwdata[7:4];
               cond_saveable   <= pwdata[11:8];
            end
            default: ;
         endcase
      end
   end

   // Completion: abort bit and error/ready status.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         error_flags  <= 8'h00;
         device_state <= 8'h40;
      end
      else if (cmd_go)
      begin
         error_flags                      <= 8'h00;
         error_flags[sfd_pkg::ERR_ABORT_B] <= abort_flag;
         device_state                     <= 8'h00;
         device_state[sfd_pkg::ST_READY_B] <= 1'b1;
         device_state[sfd_pkg::ST_ERROR_B] <= abort_flag;
      end
   end

   // Serial-link optional features.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         link_feat <= sfd_pkg::LINK_FEAT_RESET;
      end
      else if (cmd_go && link_ok)
      begin
         if (feature_selector == sfd_pkg::SEL_LINK_ENABLE)
         begin
            link_feat <= link_feat | link_mask;
         end
         else if (feature_selector == sfd_pkg::SEL_LINK_DISABLE)
         begin
            link_feat <= link_feat & ~link_mask;
         end
      end
   end

   // Revert-to-defaults switch; power-on default is disabled.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         revert_enable <= 1'b0;
      end
      else if (cmd_go && feature_selector == sfd_pkg::SEL_REVERT_ON)
      begin
         revert_enable <= 1'b1;
      end
      else if (cmd_go && feature_selector == sfd_pkg::SEL_REVERT_OFF)
      begin
         revert_enable <= 1'b0;
      end
   end

   // Power-level management settings.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         power_level_management        <= 1'b0;
         power_level                   <= 8'h00;
         deepest                       <= sfd_pkg::SFD_NORMAL;
         low_idle_timeout              <= sfd_pkg::LOWIDL_BASE_S;
         reduced_speed_standby_timeout <= sfd_pkg::STBY_BASE_S;
         low_idle_set                  <= 1'b0;
      end
      else if (reinit)
      begin
         power_level_management        <= 1'b0;
         power_level                   <= 8'h00;
         deepest                       <= sfd_pkg::SFD_NORMAL;
         low_idle_timeout              <= sfd_pkg::LOWIDL_BASE_S;
         reduced_speed_standby_timeout <= sfd_pkg::STBY_BASE_S;
         low_idle_set                  <= 1'b0;
      end
      else if (cmd_go && feature_selector == sfd_pkg::SEL_PWR_ENABLE
               && !dec_abort)
      begin
         power_level_management <= dec_deep != sfd_pkg::SFD_NORMAL;
         power_level            <= sector_count_param;
         deepest                <= dec_deep;
         unique case (dec_deep)
            sfd_pkg::SFD_LOWIDL:
            begin
               low_idle_timeout <= dec_low_s;
               low_idle_set     <= 1'b1;
            end
            sfd_pkg::SFD_STBY:
            begin
               reduced_speed_standby_timeout <= dec_stby_s;
               if (!low_idle_set)
               begin
                  low_idle_timeout <= sfd_pkg::LOWIDL_BASE_S;
                  low_idle_set     <= 1'b1;
               end
            end
            default:
            begin
               low_idle_set <= 1'b0;
            end
         endcase
      end
      else if (cmd_go && feature_selector == sfd_pkg::SEL_PWR_DISABLE)
      begin
         power_level_management <= 1'b0;
         deepest                <= sfd_pkg::SFD_NORMAL;
         low_idle_set           <= 1'b0;
      end
   end

   // Host sector-time limits.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pio_time <= 16'h0000;
         dma_time <= 16'h0000;
      end
      else if (cmd_go && feature_selector == sfd_pkg::SEL_SECTOR_TIME)
      begin
         // The PIO figure already covers host interrupt service.
         pio_time <= {sector_number_param, sector_count_param};
         dma_time <= {address_high_byte, address_mid_byte};
      end
   end

   assign pio_sector_limit = pio_time;
   assign dma_sector_limit = dma_time;
   assign pio_pacing_on    = pio_time != 16'h0000;
   assign dma_pacing_on    = dma_time != 16'h0000;

   // Power condition settings touched by the restore subcommand.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cond_enabled <= 4'hf;
         cond_saved   <= 4'hf;
      end
      else if (cmd_go && feature_selector == sfd_pkg::SEL_EXT_POWER
               && !epc_abort)
      begin
         if (sector_number_param[sfd_pkg::EPC_DEFAULT_B])
         begin
            cond_enabled <= 4'hf;
         end
         else
         begin
            cond_enabled <= cond_saved;
         end
         if (sector_number_param[sfd_pkg::EPC_SAVE_B])
         begin
            cond_saved <= sector_number_param[sfd_pkg::EPC_DEFAULT_B]
                          ? 4'hf : cond_saved;
         end
      end
   end

   // Any host activity or command returns to active, since a command also
   // restarts the idle count and may move the deepest state below pstate.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pstate <= sfd_pkg::SFD_ACT;
      end
      else if (host_activity || reinit || cmd_go
               || deepest == sfd_pkg::SFD_NORMAL)
      begin
         pstate <= sfd_pkg::SFD_ACT;
      end
      else if (deepest == sfd_pkg::SFD_STBY
               && idle_s >= reduced_speed_standby_timeout)
      begin
         pstate <= sfd_pkg::SFD_RSB;
      end
      else if (idle_s >= low_idle_timeout && pstate == sfd_pkg::SFD_ACT)
      begin
         pstate <= sfd_pkg::SFD_LIDL;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         electronics_off <= 1'b0;
         heads_parked    <= 1'b0;
         spindle_reduced <= 1'b0;
      end
      else
      begin
         electronics_off <= pstate == sfd_pkg::SFD_LIDL;
         heads_parked    <= pstate != sfd_pkg::SFD_ACT;
         spindle_reduced <= pstate == sfd_pkg::SFD_RSB;
      end
   end

   // Read side; unmapped addresses read zero without error.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata <= 32'h0;
      end
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            sfd_pkg::ADDR_COUNT:    prdata <= {24'h0, sector_count_param};
            sfd_pkg::ADDR_SECNUM:   prdata <= {24'h0, sector_number_param};
            sfd_pkg::ADDR_MID:      prdata <= {24'h0, address_mid_byte};
            sfd_pkg::ADDR_HIGH:     prdata <= {24'h0, address_high_byte};
            sfd_pkg::ADDR_DEVSEL:   prdata <= {24'h0, device_select};
            sfd_pkg::ADDR_ERROR:    prdata <= {24'h0, error_flags};
            sfd_pkg::ADDR_STATE:    prdata <= {24'h0, device_state};
            sfd_pkg::ADDR_LINKFEAT: prdata <= {27'h0, link_feat};
            sfd_pkg::ADDR_POWER:
               prdata <= {12'h0, revert_enable, pstate, deepest,
                          power_level_management, power_level, 6'h0};
            sfd_pkg::ADDR_LOWTMO:   prdata <= {19'h0, low_idle_timeout};
            sfd_pkg::ADDR_STBTMO:
               prdata <= {19'h0, reduced_speed_standby_timeout};
            sfd_pkg::ADDR_SECTIME:  prdata <= {dma_time, pio_time};
            sfd_pkg::ADDR_CONDCAP:
               prdata <= {12'h0, cond_saved, cond_enabled, cond_saveable,
                          cond_changeable, cond_supported};
            default:                prdata <= 32'h0;
         endcase
      end
   end

   assign pslverr = 1'b0;

endmodule

//--- tb/sfd_properties.sv
`timescale 1ns/1ps
module sfd_properties
#(
   parameter int unsigned SEC_CYCLES = 10
)
(
   // Clock and reset.
   input wire logic        clk,
   input wire logic        reset_n,
   // Bus and device inputs.
   input wire logic        psel,
   input wire logic        pwrite,
   input wire logic        hard_reset,
   input wire logic        host_activity,
   // Outputs.
   input wire logic        electronics_off,
   input wire logic        heads_parked,
   input wire logic        spindle_reduced,
   input wire logic [15:0] pio_sector_limit,
   input wire logic [15:0] dma_sector_limit,
   input wire logic        pio_pacing_on,
   input wire logic        dma_pacing_on
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_pio;
      pio_pacing_on == (pio_sector_limit != 16'h0);
   endproperty
   a_pio: assert property (p_pio) else $error("pio pacing wrong");
   property p_dma;
      dma_pacing_on == (dma_sector_limit != 16'h0);
   endproperty
   a_dma: assert property (p_dma) else $error("dma pacing wrong");
   property p_lowidl;
      electronics_off |-> heads_parked && !spindle_reduced;
   endproperty
   a_lowidl: assert property (p_lowidl) else $error("low idle bad");
   property p_stby;
      spindle_reduced |-> heads_parked && !electronics_off;
   endproperty
   a_stby: assert property (p_stby) else $error("standby bad");
   property p_hard;
      hard_reset |-> ##2 !heads_parked;
   endproperty
   a_hard: assert property (p_hard) else $error("hard reset kept");
   property p_act;
      host_activity |-> ##2 (!heads_parked && !spindle_reduced);
   endproperty
   a_act: assert property (p_act) else $error("activity ignored");
   property p_limits;
      $changed({pio_sector_limit, dma_sector_limit}) |->
         $past(psel && pwrite) || $past(psel && pwrite, 2);
   endproperty
   a_limits: assert property (p_limits) else $error("limit moved");
   property p_entry;
      $rose(electronics_off) |->
         $past(!host_activity) && $past(!host_activity, 8);
   endproperty
   a_entry: assert property (p_entry) else $error("early idle");
endmodule

//--- tb/sfd_host.sv
`timescale 1ns/1ps
module sfd_host
(
   // Clock.
   input  wire logic   clk,
   // Request.
   output logic        psel,
   output logic        penable,
   output logic        pwrite,
   output logic [7:0]  paddr,
   output logic [31:0] pwdata,
   // Answer.
   input  wire logic   pready
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // Taskfile bytes always go out before the command that consumes them.
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0, reset_n = 1'b0, hr = 1'b0, act = 1'b0, sr = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, eo, hp, sp, pon, don;
   logic [7:0]  paddr, x;
   logic [15:0] pl, dl, p, d;
   logic [31:0] pwdata, prdata, y, q[$];
   int          fails = 0, comparisons = 0, seed = 19657;
   initial forever #2 clk = ~clk;
   sfd_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready));
   sfd_top #(.SEC_CYCLES(10)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .hard_reset(hr),
      .soft_reset(sr), .host_activity(act), .electronics_off(eo),
      .heads_parked(hp), .spindle_reduced(sp), .pio_sector_limit(pl),
      .dma_sector_limit(dl), .pio_pacing_on(pon), .dma_pacing_on(don));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task cmd(input logic [7:0] s, input logic [7:0] c);
      host.xfer(1'b1, sfd_pkg::ADDR_FEATURE, {24'h0, s});
      host.xfer(1'b1, sfd_pkg::ADDR_COUNT, {24'h0, c});
      host.xfer(1'b1, sfd_pkg::ADDR_COMMAND, {24'h0, sfd_pkg::CMD_SET_FEATURES});
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      host.xfer(1'b0, a, 32'h0);
   endtask
   always @(posedge clk)
      if (psel && penable && !pwrite && pready)
         check(prdata | {pslverr, 31'h0}, q.pop_front());
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(8'hfc, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         x = (i == 4) ? 8'h06 : 8'(i + 1);
         cmd(sfd_pkg::SEL_LINK_ENABLE, x);
         rd(sfd_pkg::ADDR_LINKFEAT, 32'((2 << i) - 1));
      end
      cmd(sfd_pkg::SEL_LINK_ENABLE, 8'h05);
      rd(sfd_pkg::ADDR_ERROR, 32'h4);
      cmd(sfd_pkg::SEL_LINK_DISABLE, 8'h03);
      rd(sfd_pkg::ADDR_LINKFEAT, 32'h1b);
      $display("link test done");
      x = 8'h80 | (8'($random(seed)) & 8'h3f);
      y = 32'(x - 8'h80) * 5 + 120;
      cmd(sfd_pkg::SEL_PWR_ENABLE, x);
      rd(sfd_pkg::ADDR_LOWTMO, y);
      x = 8'h40 | (8'($random(seed)) & 8'h3f);
      cmd(sfd_pkg::SEL_PWR_ENABLE, x);
      rd(sfd_pkg::ADDR_STBTMO, 32'(x - 8'h40) * 60 + 600);
      rd(sfd_pkg::ADDR_LOWTMO, y);
      cmd(sfd_pkg::SEL_PWR_ENABLE, (8'($random(seed)) % 8'h3f) + 8'h01);
      rd(sfd_pkg::ADDR_STBTMO, 32'd600);
      for (int k = 0; k < 2; k++)
      begin
         cmd(sfd_pkg::SEL_PWR_ENABLE, k ? 8'hff : 8'h00);
         rd(sfd_pkg::ADDR_ERROR, 32'h4);
         rd(sfd_pkg::ADDR_STBTMO, 32'd600);
      end
      rd(sfd_pkg::ADDR_STATE, 32'h41);
      cmd(sfd_pkg::SEL_PWR_DISABLE, 8'h00);
      rd(sfd_pkg::ADDR_ERROR, 32'h0);
      $display("level test done");
      for (int k = 0; k < 2; k++)
      begin
         {p, d} = k ? 32'h0 : 32'($random(seed));
         host.xfer(1'b1, sfd_pkg::ADDR_SECNUM, {24'h0, p[15:8]});
         host.xfer(1'b1, sfd_pkg::ADDR_MID, {24'h0, d[7:0]});
         host.xfer(1'b1, sfd_pkg::ADDR_HIGH, {24'h0, d[15:8]});
         cmd(sfd_pkg::SEL_SECTOR_TIME, p[7:0]);
         rd(sfd_pkg::ADDR_SECTIME, {d, p});
         check({30'h0, don, pon}, {30'h0, d != 16'h0, p != 16'h0});
      end
      host.xfer(1'b1, sfd_pkg::ADDR_CONDCAP, 32'h0);
      host.xfer(1'b1, sfd_pkg::ADDR_SECNUM, 32'h40);
      cmd(sfd_pkg::SEL_EXT_POWER, 8'h00);
      rd(sfd_pkg::ADDR_ERROR, 32'h4);
      host.xfer(1'b1, sfd_pkg::ADDR_CONDCAP, 32'h0ff);
      host.xfer(1'b1, sfd_pkg::ADDR_SECNUM, 32'h50);
      cmd(sfd_pkg::SEL_EXT_POWER, 8'h00);
      rd(sfd_pkg::ADDR_ERROR, 32'h4);
      host.xfer(1'b1, sfd_pkg::ADDR_SECNUM, 32'h40);
      cmd(sfd_pkg::SEL_EXT_POWER, 8'h00);
      rd(sfd_pkg::ADDR_ERROR, 32'h0);
      rd(sfd_pkg::ADDR_CONDCAP, 32'hff0ff);
      cmd(8'h77, 8'h00);
      rd(sfd_pkg::ADDR_ERROR, 32'h4);
      $display("sector test done");
      cmd(sfd_pkg::SEL_PWR_ENABLE, 8'h80);
      repeat (1300) @(posedge clk);
      check({31'h0, eo}, 32'h1);
      cmd(sfd_pkg::SEL_PWR_ENABLE, 8'h01);
      repeat (6100) @(posedge clk);
      check({31'h0, sp}, 32'h1);
      sr <= 1'b1;
      @(posedge clk);
      sr <= 1'b0;
      repeat (3) @(posedge clk);
      check({31'h0, sp}, 32'h1);
      hr <= 1'b1;
      @(posedge clk);
      hr <= 1'b0;
      act <= 1'b1;
      @(posedge clk);
      act <= 1'b0;
      rd(sfd_pkg::ADDR_POWER, 32'h0);
      cmd(sfd_pkg::SEL_REVERT_ON, 8'h00);
      cmd(sfd_pkg::SEL_PWR_ENABLE, 8'h80);
      sr <= 1'b1;
      @(posedge clk);
      sr <= 1'b0;
      @(posedge clk);
      rd(sfd_pkg::ADDR_POWER, 32'h80000);
      $display("state test done");
      test_done;
   end
endmodule
bind sfd_top sfd_properties #(.SEC_CYCLES(SEC_CYCLES)) u_prop (.clk(clk),
   .reset_n(reset_n), .psel(psel), .pwrite(pwrite), .hard_reset(hard_reset),
   .host_activity(host_activity), .electronics_off(electronics_off),
   .heads_parked(heads_parked), .spindle_reduced(spindle_reduced),
   .pio_sector_limit(pio_sector_limit), .dma_sector_limit(dma_sector_limit),
   .pio_pacing_on(pio_pacing_on), .dma_pacing_on(dma_pacing_on));
